/* rtl/stc_consts.svh */
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// clock rate and time figures
`define STC_CLK_KHZ 25000
`define STC_US_PER_MS 1000
`define STC_FILT_US 1000
`define STC_TICK_US 1000

// diagnostic windows in millisecond ticks
`define STC_DISC_MS 16'h000A
`define STC_FBK_MS 16'h0002

// register byte offsets
`define STC_OFS_IRQ_STAT 5'h00
`define STC_OFS_IRQ_MASK 5'h04
`define STC_OFS_STATE 5'h08
`define STC_OFS_STOP_SEQ 5'h0C
`define STC_OFS_BRK_DLY 5'h10
`define STC_OFS_BRK_SPD 5'h14
`define STC_OFS_FLT_CLR 5'h18

// interrupt status bit positions
`define STC_IRQ_ENTER 0
`define STC_IRQ_EXIT 1
`define STC_IRQ_FLT_A 2
`define STC_IRQ_FLT_B 3

// stop sequence field positions
`define STC_SEQ_ALM_LSB 0
`define STC_SEQ_OFF_LSB 4

// reset values
`define STC_RST_MASK 4'h0
`define STC_RST_SEQ 4'h0
`define STC_RST_BRK_DLY 16'h0032
`define STC_RST_BRK_SPD 16'h001E

// alarm codes
`define STC_CODE_NONE 2'h0
`define STC_SAFETY_FAULT_CODE_A 2'h1
`define STC_SAFETY_FAULT_CODE_B 2'h2

`endif

/* rtl/stc_filter.sv */
`timescale 1ns/100ps
`include "stc_consts.svh"

module stc_filter
  import stc_pkg::*;
#(
  parameter logic [14:0] FILT_CYC = 15'h61A8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // raw pin, high while the input photocoupler conducts
  input wire logic pin,
  // filtered level, high means channel asserted
  output logic level
);

  stc_filt_t s_q;
  stc_filt_t s_d;

  // sync1 feeds only sync2; the filter looks at sync2 alone
  always_comb begin
    s_d = s_q;
    s_d.sync1 = pin;
    s_d.sync2 = s_q.sync1;
    if (s_q.sync2 == s_q.level) begin
      s_d.cnt = 15'h0000;
    end else if (s_q.cnt == FILT_CYC - 15'h0001) begin
      // held long enough: accept the new level
      s_d.level = s_q.sync2; // RULE9
      s_d.cnt = 15'h0000;
    end else begin
      // any bounce back restarts the window, so diagnostic pulses vanish
      s_d.cnt = s_q.cnt + 15'h0001; // RULE18
    end
  end

  // state register; reset to asserted-off so the drive starts cut
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;

endmodule : stc_filter

/* rtl/stc_pkg.sv */
package stc_pkg;

  // drive operating mode seen by this block
  typedef enum logic [1:0] {
    SRV_OFF,
    SRV_ON,
    SAFE_CUT
  } stc_mode_t;

  // three phase gate drive, upper and lower arms
  typedef struct packed {
    logic [2:0] upper;
    logic [2:0] lower;
  } stc_gate_t;

  // state of one safety input filter
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic [14:0] cnt;
  } stc_filt_t;

  // whole state of the top module
  typedef struct packed {
    stc_mode_t mode;
    stc_gate_t gate;
    logic cut;
    logic mon;
    logic ready;
    logic brake;
    logic brk_arm;
    logic [15:0] brk_cnt;
    logic [14:0] tick_cnt;
    logic tick;
    logic [15:0] disc_cnt;
    logic [15:0] fbk_cnt;
    logic fb_s1;
    logic fb_s2;
    logic son_s1;
    logic son_s2;
    logic son_prev;
    logic alarm;
    logic [1:0] code;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] alm_seq;
    logic [3:0] off_seq;
    logic [3:0] db_mode;
    logic [15:0] brk_dly;
    logic [15:0] brk_spd;
    logic ack;
    logic [31:0] rdata;
  } stc_top_t;

endpackage : stc_pkg

/* rtl/stc_top.sv */
// Summary of operation
// RULE1: either safety channel off puts the drive into safe torque cut, no torque.
// RULE2: channel a off forces all upper arm gate drives inactive on its own.
// RULE3: channel b off forces all lower arm gate drives inactive on its own.
// RULE4: in safe torque cut servo ready drops and the safety display lights.
// RULE5: safety channel off with servo-on inactive means servo-off status.
// RULE6: entering safe torque cut raises no alarm by itself.
// RULE7: diagnostic faults raise an alarm with one of two fault codes.
// RULE8: torque is removed within 5 ms of a valid channel off.
// RULE9: off intervals shorter than 1 ms are filtered out.
// RULE10: the safety equipment holds a genuine off request longer than 5 ms.
// RULE11: monitor output is on only when both channels are off.
// RULE12: monitor output follows the inputs within 6 ms.
// RULE13: the external device checks all four input states against the monitor.
// RULE14: the host keeps servo-on inactive while re-asserting both channels.
// RULE15: both channels back on returns to servo-off with no alarm clear.
// RULE16: brake mode uses alarm sequence in cut, servo-off sequence afterwards.
// RULE17: brake released output drops at delay expiry or low speed, first wins.
// RULE18: filtering and timing use synchronous counters on synchronised inputs.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "stc_consts.svh"

module stc_top
  import stc_pkg::*;
#(
  parameter int FILT_CYC = `STC_FILT_US * `STC_CLK_KHZ / `STC_US_PER_MS,
  parameter int TICK_CYC = `STC_TICK_US * `STC_CLK_KHZ / `STC_US_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // safety input pins, high while the photocoupler conducts
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  // monitor output and its readback pin
  output logic ext_monitor_out,
  input wire logic ext_monitor_fb,
  // servo-on pin and drive-side status
  input wire logic servo_on_in,
  input wire logic drive_ready,
  input wire logic [15:0] motor_speed,
  // gate drive path
  input wire stc_gate_t pwm_in,
  output stc_gate_t gate_out,
  // drive status outputs
  output logic safe_torque_cut,
  output logic servo_ready,
  output logic servo_off_stat,
  output logic safety_state_display,
  output stc_mode_t drive_mode,
  output logic brake_release,
  output logic [3:0] dyn_brake_mode,
  output logic alarm,
  output logic [1:0] alarm_code,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq
);

  localparam logic [14:0] FILT_W = 15'(FILT_CYC);
  localparam logic [14:0] TICK_W = 15'(TICK_CYC);

  stc_top_t s_q;
  stc_top_t s_d;

  logic a_on;
  logic b_on;
  logic cut_now;
  logic son;
  logic son_rise;
  logic req;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic [3:0] ev;
  logic flt_a;
  logic flt_b;

  // one filter per safety channel
  stc_filter #(
    .FILT_CYC(FILT_W)
  ) u_filt_a (
    .clk(clk),
    .arst_n(arst_n),
    .pin(safety_input_a),
    .level(a_on)
  );

  stc_filter #(
    .FILT_CYC(FILT_W)
  ) u_filt_b (
    .clk(clk),
    .arst_n(arst_n),
    .pin(safety_input_b),
    .level(b_on)
  );

  // decoded conditions shared by the next-state logic
  assign cut_now = ~a_on | ~b_on; // RULE1
  assign son = s_q.son_s2;
  assign son_rise = s_q.son_s2 & ~s_q.son_prev;
  assign req = avs_read | avs_write;
  assign wr_go = avs_write & s_q.ack;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd = avs_writedata & wmask;
  // a channel mismatch or a dead monitor driver, held over its window
  assign flt_a = (s_q.disc_cnt == `STC_DISC_MS) & ~s_q.alarm;
  assign flt_b = (s_q.fbk_cnt == `STC_FBK_MS) & ~s_q.alarm;

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    ev = 4'h0;

    // pin synchronisers; first stages are read by the second only
    s_d.son_s1 = servo_on_in;
    s_d.son_s2 = s_q.son_s1;
    s_d.son_prev = s_q.son_s2;
    s_d.fb_s1 = ext_monitor_fb;
    s_d.fb_s2 = s_q.fb_s1;

    // millisecond enable for the slow timers
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == TICK_W - 15'h0001) begin
      s_d.tick_cnt = 15'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 15'h0001;
    end

    // operating mode; servo-on must rise again before torque returns
    unique case (s_q.mode)
      SRV_OFF: begin
        if (cut_now) begin
          s_d.mode = SAFE_CUT;
          ev[`STC_IRQ_ENTER] = 1'b1;
        end else if (son_rise && !s_q.alarm) begin
          s_d.mode = SRV_ON;
        end
      end
      SRV_ON: begin
        if (cut_now) begin
          s_d.mode = SAFE_CUT; // RULE1
          s_d.brk_arm = 1'b1;
          s_d.brk_cnt = 16'h0000;
          ev[`STC_IRQ_ENTER] = 1'b1;
        end else if (!son || s_q.alarm) begin
          s_d.mode = SRV_OFF;
        end
      end
      SAFE_CUT: begin
        // waiting for servo-on low keeps a restart from jumping into torque
        if (!cut_now && !son) begin
          s_d.mode = SRV_OFF; // RULE15
          ev[`STC_IRQ_EXIT] = 1'b1;
        end
      end
    endcase

    // gate drive, each arm gated by its own channel and also by the cut from either channel
    s_d.gate.upper = (a_on && s_q.mode == SRV_ON && !cut_now) ? pwm_in.upper : 3'h0; // RULE2
    s_d.gate.lower = (b_on && s_q.mode == SRV_ON && !cut_now) ? pwm_in.lower : 3'h0; // RULE3
    s_d.gate.upper = a_on ? s_d.gate.upper : 3'h0; // RULE8
    s_d.gate.lower = b_on ? s_d.gate.lower : 3'h0; // RULE8
    s_d.cut = cut_now;

    // monitor on only with both channels off
    s_d.mon = ~a_on & ~b_on; // RULE11 RULE12

    // ready drops in cut; cut itself leaves the alarm alone
    s_d.ready = drive_ready & ~cut_now & ~s_q.alarm; // RULE4 RULE6

    // brake release: held while running, dropped at delay or low speed
    if (s_d.mode == SRV_ON) begin
      s_d.brake = 1'b1;
      s_d.brk_arm = 1'b0;
    end else if (s_q.brk_arm) begin
      if (s_q.brk_cnt >= s_q.brk_dly || motor_speed < s_q.brk_spd) begin
        s_d.brake = 1'b0; // RULE17
        s_d.brk_arm = 1'b0;
      end else if (s_q.tick) begin
        s_d.brk_cnt = s_q.brk_cnt + 16'h0001;
      end
    end else if (!s_d.brk_arm) begin
      // on the entry cycle the arm is only just set, so the release holds
      s_d.brake = 1'b0;
    end

    // dynamic brake mode follows the state the drive sits in
    s_d.db_mode = (s_d.mode == SAFE_CUT) ? s_q.alm_seq : s_q.off_seq; // RULE16

    // diagnostic timers, counted in millisecond ticks
    if (a_on == b_on) begin
      s_d.disc_cnt = 16'h0000;
    end else if (s_q.tick && s_q.disc_cnt != `STC_DISC_MS) begin
      s_d.disc_cnt = s_q.disc_cnt + 16'h0001; // RULE18
    end
    if (s_q.fb_s2 == s_q.mon) begin
      s_d.fbk_cnt = 16'h0000;
    end else if (s_q.tick && s_q.fbk_cnt != `STC_FBK_MS) begin
      s_d.fbk_cnt = s_q.fbk_cnt + 16'h0001;
    end

    // alarm clear by software, only once the fault is gone
    if (wr_go && avs_address == `STC_OFS_FLT_CLR && wd[0] &&
        s_q.disc_cnt == 16'h0000 && s_q.fbk_cnt == 16'h0000) begin
      s_d.alarm = 1'b0;
      s_d.code = `STC_CODE_NONE;
    end
    // a fresh fault wins over a clear in the same cycle
    if (flt_a) begin
      s_d.alarm = 1'b1; // RULE7
      s_d.code = `STC_SAFETY_FAULT_CODE_A;
      ev[`STC_IRQ_FLT_A] = 1'b1;
    end else if (flt_b) begin
      s_d.alarm = 1'b1; // RULE7
      s_d.code = `STC_SAFETY_FAULT_CODE_B;
      ev[`STC_IRQ_FLT_B] = 1'b1;
    end

    // bus handshake: one wait cycle, then the access completes
    s_d.ack = req & ~s_q.ack;

    // register writes
    if (wr_go) begin
      unique case (avs_address)
        `STC_OFS_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~wd[3:0];
        `STC_OFS_IRQ_MASK: s_d.irq_mask = wd[3:0];
        `STC_OFS_STOP_SEQ: begin
          s_d.alm_seq = wd[`STC_SEQ_ALM_LSB +: 4];
          s_d.off_seq = wd[`STC_SEQ_OFF_LSB +: 4];
        end
        `STC_OFS_BRK_DLY: s_d.brk_dly = wd[15:0];
        `STC_OFS_BRK_SPD: s_d.brk_spd = wd[15:0];
        default: begin
        end
      endcase
    end
    // events set after the clear so a coincident event is kept
    s_d.irq_stat = s_d.irq_stat | ev;

    // register reads, captured in the wait cycle
    if (avs_read && !s_q.ack) begin
      unique case (avs_address)
        `STC_OFS_IRQ_STAT: s_d.rdata = {28'h000_0000, s_q.irq_stat};
        `STC_OFS_IRQ_MASK: s_d.rdata = {28'h000_0000, s_q.irq_mask};
        `STC_OFS_STATE: s_d.rdata = {20'h0_0000, s_q.code, s_q.alarm, s_q.brake,
                                     s_q.ready, s_q.mode, s_q.mon, s_q.cut,
                                     b_on, a_on, son};
        `STC_OFS_STOP_SEQ: s_d.rdata = {24'h00_0000, s_q.off_seq, s_q.alm_seq};
        `STC_OFS_BRK_DLY: s_d.rdata = {16'h0000, s_q.brk_dly};
        `STC_OFS_BRK_SPD: s_d.rdata = {16'h0000, s_q.brk_spd};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.mode <= SAFE_CUT;
      s_q.cut <= 1'b1;
      s_q.irq_mask <= `STC_RST_MASK;
      s_q.alm_seq <= `STC_RST_SEQ;
      s_q.off_seq <= `STC_RST_SEQ;
      s_q.db_mode <= `STC_RST_SEQ;
      s_q.brk_dly <= `STC_RST_BRK_DLY;
      s_q.brk_spd <= `STC_RST_BRK_SPD;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs, all from registers except the bus handshake
  assign gate_out = s_q.gate;
  assign safe_torque_cut = s_q.cut;
  assign ext_monitor_out = s_q.mon;
  assign servo_ready = s_q.ready;
  assign safety_state_display = (s_q.mode == SAFE_CUT); // RULE4
  assign servo_off_stat = (s_q.mode == SRV_OFF) | ((s_q.mode == SAFE_CUT) & ~son); // RULE5
  assign drive_mode = s_q.mode;
  assign brake_release = s_q.brake;
  assign dyn_brake_mode = s_q.db_mode;
  assign alarm = s_q.alarm;
  assign alarm_code = s_q.code;
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = req & ~s_q.ack;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

endmodule : stc_top

/* test/stc_properties.sv */
`timescale 1ns/100ps
module stc_checker
  import stc_pkg::*;
#(
  parameter int FILT_CYC = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // safety side
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic servo_on_in,
  input wire logic ext_monitor_out,
  // drive side
  input wire stc_gate_t gate_out,
  input wire logic safe_torque_cut,
  input wire logic servo_ready,
  input wire logic servo_off_stat,
  input wire logic safety_state_display,
  input wire logic alarm
);
  // sync, filter and output register latency with a small margin
  localparam int LAT = FILT_CYC + 6;
  int lo_a_q;
  int lo_b_q;
  int hi_a_q;
  int hi_b_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // low run length of each pin, saturating so it never wraps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_a_q <= 0;
      lo_b_q <= 0;
      hi_a_q <= 0;
      hi_b_q <= 0;
    end else begin
      lo_a_q <= safety_input_a ? 0 : (lo_a_q < LAT ? lo_a_q + 1 : LAT);
      lo_b_q <= safety_input_b ? 0 : (lo_b_q < LAT ? lo_b_q + 1 : LAT);
      // high run length, so the monitor is judged against the pins themselves
      hi_a_q <= !safety_input_a ? 0 : (hi_a_q < LAT ? hi_a_q + 1 : LAT);
      hi_b_q <= !safety_input_b ? 0 : (hi_b_q < LAT ? hi_b_q + 1 : LAT);
    end
  end
  property p_cut; (lo_a_q == LAT) || (lo_b_q == LAT) |-> safe_torque_cut; endproperty
  property p_up; lo_a_q == LAT |-> gate_out.upper == 3'h0; endproperty
  property p_low; lo_b_q == LAT |-> gate_out.lower == 3'h0; endproperty
  property p_rdy; $rose(safe_torque_cut) |-> safety_state_display ##1 !servo_ready; endproperty
  property p_off; (!servo_on_in)[*4] ##0 safety_state_display |-> servo_off_stat; endproperty
  property p_alm; $rose(safe_torque_cut) && !alarm |=> !alarm; endproperty
  property p_mon; lo_a_q == LAT && lo_b_q == LAT |-> ext_monitor_out; endproperty
  property p_mon_x; (hi_a_q == LAT) || (hi_b_q == LAT) |-> !ext_monitor_out; endproperty
  a_cut: assert property (p_cut) else $error("torque not cut after channel off");
  a_up: assert property (p_up) else $error("upper arm still driven");
  a_low: assert property (p_low) else $error("lower arm still driven");
  a_rdy: assert property (p_rdy) else $error("ready or display wrong in cut");
  a_off: assert property (p_off) else $error("servo off status missing");
  a_alm: assert property (p_alm) else $error("alarm raised by cut entry");
  a_mon: assert property (p_mon) else $error("monitor late with both off");
  a_mon_x: assert property (p_mon_x) else $error("monitor on with channel on");
  // main scenarios seen
  c_cut: cover property ($rose(safe_torque_cut));
  c_mon: cover property ($rose(ext_monitor_out));
  c_alm: cover property ($rose(alarm));
endmodule : stc_checker

/* test/stc_safety_ctrl.sv */
`timescale 1ns/100ps
module stc_safety_ctrl #(
  parameter int MON_LAT = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // channel states asked by the bench
  input wire logic want_a,
  input wire logic want_b,
  // pins and monitor readback
  output logic safety_input_a,
  output logic safety_input_b,
  input wire logic ext_monitor_out,
  output logic anomaly
);
  int stab_q;
  // off requests are held by the bench well beyond the filter
  assign safety_input_a = want_a;
  assign safety_input_b = want_b;
  // compare monitor once the inputs have settled, all four states
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stab_q <= 0;
      anomaly <= 1'b0;
    end else begin
      stab_q <= ($changed(want_a) || $changed(want_b)) ? 0 : stab_q + 1;
      if (stab_q > MON_LAT && ext_monitor_out !== (!want_a && !want_b)) begin
        anomaly <= 1'b1;
      end
    end
  end
endmodule : stc_safety_ctrl

/* test/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import stc_pkg::*;
;
  localparam int FILT = 16;
  localparam int LAT = FILT + 6;
  logic clk, arst_n, want_a, want_b, sa, sb, son, mon, anom;
  logic cut, rdy, offs, disp, brk, alm, rd, wr, wt, irq;
  logic [15:0] spd;
  logic [3:0] dbm, be;
  logic [1:0] code;
  logic [4:0] addr;
  logic [31:0] wd, rdat, q;
  stc_gate_t pwm, gate;
  stc_mode_t mode;
  int mismatches = 0;
  int cmp_count = 0;
  stc_top #(.FILT_CYC(FILT), .TICK_CYC(8)) u_stc_top (.clk(clk), .arst_n(arst_n),
    .safety_input_a(sa), .safety_input_b(sb), .ext_monitor_out(mon), .ext_monitor_fb(mon),
    .servo_on_in(son), .drive_ready(1'b1), .motor_speed(spd), .pwm_in(pwm), .gate_out(gate),
    .safe_torque_cut(cut), .servo_ready(rdy), .servo_off_stat(offs),
    .safety_state_display(disp), .drive_mode(mode), .brake_release(brk),
    .dyn_brake_mode(dbm), .alarm(alm), .alarm_code(code), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wt), .irq(irq));
  stc_safety_ctrl #(.MON_LAT(LAT + 8)) u_stc_safety_ctrl (.clk(clk), .arst_n(arst_n),
    .want_a(want_a), .want_b(want_b), .safety_input_a(sa), .safety_input_b(sb),
    .ext_monitor_out(mon), .anomaly(anom));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // one avalon access; waitrequest and read data taken at the rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wait_mode(input stc_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_mode
  task automatic t_regs();
    bus(0, 5'h04, 0); chk("mask", q, 32'h0000_0000);
    bus(0, 5'h10, 0); chk("brk_dly", q, 32'h0000_0032);
    bus(0, 5'h14, 0); chk("brk_spd", q, 32'h0000_001E);
    bus(0, 5'h1C, 0); chk("unmapped", q, 32'h0000_0000);
    bus(1, 5'h0C, 32'h0000_0053);
    bus(0, 5'h0C, 0); chk("stop_seq", q, 32'h0000_0053);
    $display("regs done");
  endtask : t_regs
  // both channels back on with servo-on low
  task automatic t_exit();
    @(posedge clk);
    want_a <= 1'b1;
    want_b <= 1'b1;
    wait_mode(SRV_OFF);
    cyc(2);
    chk("alarm", alm, 1'b0);
    chk("mon", mon, 1'b0);
    chk("dbm", dbm, 4'h5);
    bus(1, 5'h04, 32'h0000_0002);
    cyc(1);
    chk("irq", irq, 1'b1);
    bus(1, 5'h00, 32'h0000_000F);
    cyc(1);
    chk("irq_clr", irq, 1'b0);
    $display("exit done");
  endtask : t_exit
  // self-test pulse shorter than the filter
  task automatic t_glitch();
    @(posedge clk);
    want_a <= 1'b0;
    cyc(FILT / 2);
    @(posedge clk);
    want_a <= 1'b1;
    cyc(LAT);
    chk("glitch_cut", cut, 1'b0);
    $display("glitch done");
  endtask : t_glitch
  task automatic t_cut_a();
    @(posedge clk);
    pwm <= 6'h3F;
    spd <= 16'h0064;
    son <= 1'b1;
    wait_mode(SRV_ON);
    cyc(2);
    chk("gate_on", gate, 6'h3F);
    chk("brk_on", brk, 1'b1);
    @(posedge clk);
    want_a <= 1'b0;
    spd <= 16'h0005;
    wait_mode(SAFE_CUT);
    cyc(3);
    chk("upper", gate.upper, 3'h0);
    chk("cut", cut, 1'b1);
    chk("ready", {rdy, disp}, 2'b01);
    chk("alarm", alm, 1'b0);
    chk("mon_a", mon, 1'b0);
    chk("dbm", dbm, 4'h3);
    chk("brk_spd", brk, 1'b0);
    @(posedge clk);
    want_b <= 1'b0;
    son <= 1'b0;
    cyc(LAT);
    chk("mon_ab", mon, 1'b1);
    chk("offstat", offs, 1'b1);
    t_exit();
  endtask : t_cut_a
  // lower arm cut, brake delay, then a channel mismatch fault
  task automatic t_cut_b();
    bus(1, 5'h10, 32'h0000_0002);
    @(posedge clk);
    spd <= 16'h0064;
    son <= 1'b1;
    wait_mode(SRV_ON);
    @(posedge clk);
    want_b <= 1'b0;
    wait_mode(SAFE_CUT);
    cyc(2);
    chk("lower", gate.lower, 3'h0);
    chk("brk_hold", brk, 1'b1);
    cyc(30);
    chk("brk_dly", brk, 1'b0);
    cyc(120);
    chk("fault", {alm, code}, 3'b101);
    bus(0, 5'h00, 0);
    chk("stat_flt", q, 32'h0000_0005);
    @(posedge clk);
    son <= 1'b0;
    want_b <= 1'b1;
    cyc(LAT + 4);
    bus(1, 5'h18, 32'h0000_0001);
    cyc(3);
    chk("flt_clr", {alm, mode}, {1'b0, SRV_OFF});
    $display("cut b done");
  endtask : t_cut_b
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {arst_n, want_a, want_b, son, rd, wr} = '0;
    {spd, pwm, addr, wd} = '0;
    be = 4'hF;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_exit();
    t_glitch();
    t_cut_a();
    t_cut_b();
    chk("anomaly", anom, 1'b0);
    stop_test();
  end
endmodule : tb_top
bind stc_top stc_checker #(.FILT_CYC(FILT_CYC)) u_stc_checker (.clk, .arst_n,
  .safety_input_a, .safety_input_b, .servo_on_in, .ext_monitor_out, .gate_out,
  .safe_torque_cut, .servo_ready, .servo_off_stat, .safety_state_display, .alarm);
